// ### src/chan_pkg.sv
// Purpose: shared constants for one timer channel in timer mode
// Assumes: 32-bit register bus, one aligned word per register
// Notes: offsets are byte addresses on the register bus
package chan_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int PRE_W = 5;
  // register offsets
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_RUN = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h1c;
  localparam logic [7:0] OFF_CMP0 = 8'h20;
  localparam logic [7:0] OFF_CMP1 = 8'h24;
  localparam logic [7:0] OFF_CAP0 = 8'h28;
  localparam logic [7:0] OFF_CAP1 = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  // field positions
  localparam int B_OPSEL = 0;
  localparam int B_RUN = 0;
  localparam int B_PRERUN = 2;
  localparam int B_DBE = 7;
  localparam int B_PAIR = 6;
  localparam int B_SCAP = 5;
  localparam int B_CPM = 3;
  localparam int B_IDLE = 3;
  localparam int B_CLE = 2;
  localparam int B_TRG = 1;
  localparam int B_CSS = 0;
  localparam int B_CLK = 0;
  // writable masks, reset values, read-as-one bits
  localparam logic [7:0] CTRL_MASK = 8'heb;
  localparam logic [7:0] MODE_MASK = 8'h5f;
  localparam logic [7:0] MODE_RD_SET = 8'h20;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  typedef enum logic [1:0] {
    CPM_OFF_LO = 2'b00,
    CPM_RISE = 2'b01,
    CPM_BOTH = 2'b10,
    CPM_OFF_HI = 2'b11
  } capture_mode_t;
  typedef enum logic [1:0] {
    CLK_PIN = 2'b00,
    CLK_T1 = 2'b01,
    CLK_T4 = 2'b10,
    CLK_T16 = 2'b11
  } clock_select_t;
  // prescaler tap masks: tap fires when all masked bits are one
  localparam logic [PRE_W-1:0] TAP_T1 = 5'h01;
  localparam logic [PRE_W-1:0] TAP_T4 = 5'h07;
  localparam logic [PRE_W-1:0] TAP_T16 = 5'h1f;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### src/tick_source.sv
// Purpose: pin synchroniser, pin edges, prescaler and count tick select
// Assumes: pin is asynchronous to aclk
// Notes: taps are one-cycle enables of aclk
`timescale 1ns/1ns
module tick_source (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic prescaler_run,
  input wire logic [1:0] count_clock_select,
  // pin
  input wire logic timer_input_pin,
  // events
  output logic count_tick,
  output logic pin_rise,
  output logic pin_fall
);
  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic [chan_pkg::PRE_W-1:0] pre_q;
  logic [chan_pkg::PRE_W-1:0] tap_mask;
  logic tap_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sync1_q <= timer_input_pin;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !prescaler_run) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign pin_rise = sync2_q && !last_q;
  assign pin_fall = !sync2_q && last_q;
  assign tap_mask = (count_clock_select == chan_pkg::CLK_T1) ? chan_pkg::TAP_T1 :
                    (count_clock_select == chan_pkg::CLK_T4) ? chan_pkg::TAP_T4 :
                    chan_pkg::TAP_T16;
  assign tap_hit = prescaler_run && ((pre_q & tap_mask) == tap_mask);
  // pin edge or selected prescaler tap
  assign count_tick = (count_clock_select == chan_pkg::CLK_PIN) ? pin_rise : tap_hit;
endmodule

// ### src/compare_buffer.sv
// Purpose: compare value pair with optional double buffering
// Assumes: load_evt marks counter clear, overflow or stopped counter
// Notes: a write in the load cycle stays pending
`timescale 1ns/1ns
module compare_buffer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // writes
  input wire logic wr0,
  input wire logic wr1,
  input wire logic [chan_pkg::CNT_W-1:0] wdata,
  // control
  input wire logic buffered,
  input wire logic pairing,
  input wire logic load_evt,
  // state
  output logic [chan_pkg::CNT_W-1:0] value0,
  output logic [chan_pkg::CNT_W-1:0] value1,
  output logic pending0,
  output logic pending1
);
  logic [chan_pkg::CNT_W-1:0] buf0_q;
  logic [chan_pkg::CNT_W-1:0] buf1_q;
  logic load0;
  logic load1;

  // pairing withholds a load until both are prepared
  assign load0 = buffered && load_evt && pending0 && (!pairing || pending1);
  assign load1 = buffered && load_evt && pending1 && (!pairing || pending0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf0_q <= '0;
      buf1_q <= '0;
      value0 <= '0;
      value1 <= '0;
      pending0 <= 1'b0;
      pending1 <= 1'b0;
    end else begin
      if (wr0) begin
        buf0_q <= wdata;
      end
      if (wr1) begin
        buf1_q <= wdata;
      end
      // direct write when unbuffered, else via shadow
      if (wr0 && !buffered) begin
        value0 <= wdata;
      end else if (load0) begin
        value0 <= buf0_q;
      end
      if (wr1 && !buffered) begin
        value1 <= wdata;
      end else if (load1) begin
        value1 <= buf1_q;
      end
      pending0 <= buffered && (wr0 || (pending0 && !load0));
      pending1 <= buffered && (wr1 || (pending1 && !load1));
    end
  end
endmodule

// ### src/timer_channel_control_and_mode.sv
// Purpose: control and mode of one timer channel with AXI4-Lite access
// Assumes: software changes control and mode only while stopped
// Notes: counter, compare and capture words are 16 bits, upper bits zero
// Functional notes
// - control bit 7 enables compare double buffering; off after reset.
// - power-switching mode forces double buffering regardless of bit 7.
// - control bit 3 keeps counting in idle when 1, stops it when 0.
// - control bit 1 picks rising (0) or falling (1) trigger edge.
// - control bit 0 starts counting by software (0) or trigger edge (1).
// - mode bit 6 set withholds compare loads until both are prepared.
// - writing 0 to mode bit 5 copies the counter into capture 0.
// - mode bit 5 always reads 1.
// - capture codes 00 and 11 disable hardware capture.
// - code 01 captures on rising pin; 10 also captures 1 on falling.
// - mode bit 2 clears the counter on a compare 1 match.
// - mode bits 1:0 pick pin, or prescaler taps firing every two, eight, thirty-two cycles.
// - clearing run stops and zeroes the counter; setting it allows counting.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
module timer_channel_control_and_mode (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [chan_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [chan_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // system and pin
  input wire logic idle_req,
  input wire logic timer_input_pin,
  // status
  output logic [chan_pkg::CNT_W-1:0] counter_value
);
  localparam int W = chan_pkg::CNT_W;

  logic aw_hold_q;
  logic w_hold_q;
  logic [chan_pkg::ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic op_select_q;
  logic run_q;
  logic prerun_q;
  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic started_q;
  logic [W-1:0] cap0_q;
  logic [W-1:0] cap1_q;
  logic [W-1:0] cmp0;
  logic [W-1:0] cmp1;
  logic pend0;
  logic pend1;
  logic count_tick;
  logic pin_rise;
  logic pin_fall;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // bus handshake and decode
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  logic w_hit;
  logic r_hit;
  assign awready = !aw_hold_q && !bvalid;
  assign wready = !w_hold_q && !bvalid;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid;
  assign arready = !rvalid;
  assign ar_take = arvalid && arready;

  function automatic logic mapped(input logic [chan_pkg::ADDR_W-1:0] a);
    return a == chan_pkg::OFF_ENABLE || a == chan_pkg::OFF_RUN ||
           a == chan_pkg::OFF_CTRL || a == chan_pkg::OFF_MODE ||
           a == chan_pkg::OFF_COUNT || a == chan_pkg::OFF_CMP0 ||
           a == chan_pkg::OFF_CMP1 || a == chan_pkg::OFF_CAP0 ||
           a == chan_pkg::OFF_CAP1 || a == chan_pkg::OFF_STATUS;
  endfunction
  assign w_hit = mapped(waddr_q);
  assign r_hit = mapped(araddr);

  logic wr_enable;
  logic wr_run;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cmp0;
  logic wr_cmp1;
  assign wr_enable = wr_fire && waddr_q == chan_pkg::OFF_ENABLE;
  assign wr_run = wr_fire && waddr_q == chan_pkg::OFF_RUN;
  assign wr_ctrl = wr_fire && waddr_q == chan_pkg::OFF_CTRL;
  assign wr_mode = wr_fire && waddr_q == chan_pkg::OFF_MODE;
  assign wr_cmp0 = wr_fire && waddr_q == chan_pkg::OFF_CMP0;
  assign wr_cmp1 = wr_fire && waddr_q == chan_pkg::OFF_CMP1;

  logic [31:0] wmerge;
  logic [W-1:0] cmp_wval;
  logic soft_cap;
  assign wmerge = merge(32'h0000_0000, wdata_q, wstrb_q);
  assign cmp_wval = wmerge[W-1:0];
  // strobe acts on a written zero only, one is ignored
  assign soft_cap = wr_mode && wstrb_q[0] && !wdata_q[chan_pkg::B_SCAP];

  // control and mode fields
  logic dbe;
  logic idle_run;
  logic trg_fall;
  logic start_ext;
  logic pairing;
  logic [1:0] cpm;
  logic clear_en;
  logic [1:0] clk_sel;
  logic buffered;
  assign dbe = ctrl_q[chan_pkg::B_DBE];
  assign idle_run = ctrl_q[chan_pkg::B_IDLE];
  assign trg_fall = ctrl_q[chan_pkg::B_TRG];
  assign start_ext = ctrl_q[chan_pkg::B_CSS];
  assign pairing = mode_q[chan_pkg::B_PAIR];
  assign cpm = mode_q[chan_pkg::B_CPM +: 2];
  assign clear_en = mode_q[chan_pkg::B_CLE];
  assign clk_sel = mode_q[chan_pkg::B_CLK +: 2];
  assign buffered = dbe || op_select_q;

  // counting
  logic trig_evt;
  logic clk_live;
  logic count_en;
  logic match1;
  logic clear_hit;
  logic ovf;
  logic load_evt;
  logic [W-1:0] cnt_d;
  assign trig_evt = trg_fall ? pin_fall : pin_rise;
  assign clk_live = !idle_req || idle_run;
  assign count_en = run_q && started_q && count_tick && clk_live;
  assign match1 = counter_value == cmp1;
  assign clear_hit = count_en && clear_en && match1;
  assign ovf = count_en && counter_value == chan_pkg::CNT_MAX;
  assign load_evt = clear_hit || ovf || !run_q;
  assign cnt_d = !run_q ? '0 :
                 clear_hit ? '0 :
                 count_en ? W'(counter_value + 1'b1) : counter_value;

  // capture
  logic cap_rise;
  logic cap_fall;
  assign cap_rise = pin_rise && (cpm == chan_pkg::CPM_RISE || cpm == chan_pkg::CPM_BOTH);
  assign cap_fall = pin_fall && cpm == chan_pkg::CPM_BOTH;

  // read mux
  logic [31:0] rd_word;
  assign rd_word =
    (araddr == chan_pkg::OFF_ENABLE) ? {31'h0000_0000, op_select_q} :
    (araddr == chan_pkg::OFF_RUN) ? {29'h0000_0000, prerun_q, 1'b0, run_q} :
    (araddr == chan_pkg::OFF_CTRL) ? {24'h00_0000, ctrl_q} :
    (araddr == chan_pkg::OFF_MODE) ? {24'h00_0000, mode_q | chan_pkg::MODE_RD_SET} :
    (araddr == chan_pkg::OFF_COUNT) ? {16'h0000, counter_value} :
    (araddr == chan_pkg::OFF_CMP0) ? {16'h0000, cmp0} :
    (araddr == chan_pkg::OFF_CMP1) ? {16'h0000, cmp1} :
    (araddr == chan_pkg::OFF_CAP0) ? {16'h0000, cap0_q} :
    (araddr == chan_pkg::OFF_CAP1) ? {16'h0000, cap1_q} :
    (araddr == chan_pkg::OFF_STATUS) ? {28'h000_0000, pend1, pend0, count_en, started_q} :
    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= chan_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        waddr_q <= awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= w_hit ? chan_pkg::RESP_OKAY : chan_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= chan_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= r_hit ? chan_pkg::RESP_OKAY : chan_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_select_q <= 1'b0;
      run_q <= 1'b0;
      prerun_q <= 1'b0;
      ctrl_q <= chan_pkg::RST_CTRL;
      mode_q <= chan_pkg::RST_MODE;
    end else begin
      if (wr_enable && wstrb_q[0]) begin
        op_select_q <= wdata_q[chan_pkg::B_OPSEL];
      end
      if (wr_run && wstrb_q[0]) begin
        run_q <= wdata_q[chan_pkg::B_RUN];
        prerun_q <= wdata_q[chan_pkg::B_PRERUN];
      end
      if (wr_ctrl && wstrb_q[0]) begin
        ctrl_q <= wdata_q[7:0] & chan_pkg::CTRL_MASK;
      end
      if (wr_mode && wstrb_q[0]) begin
        mode_q <= wdata_q[7:0] & chan_pkg::MODE_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      started_q <= 1'b0;
      counter_value <= '0;
      cap0_q <= '0;
      cap1_q <= '0;
    end else begin
      // software start at once, trigger start waits for the edge
      started_q <= run_q && (started_q || !start_ext || trig_evt);
      counter_value <= cnt_d;
      if (soft_cap || cap_rise) begin
        cap0_q <= counter_value;
      end
      if (cap_fall) begin
        cap1_q <= counter_value;
      end
    end
  end

  tick_source u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .prescaler_run(prerun_q),
    .count_clock_select(clk_sel),
    .timer_input_pin(timer_input_pin),
    .count_tick(count_tick),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
  );

  compare_buffer u_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr0(wr_cmp0 && |wstrb_q[1:0]),
    .wr1(wr_cmp1 && |wstrb_q[1:0]),
    .wdata(cmp_wval),
    .buffered(buffered),
    .pairing(pairing),
    .load_evt(load_evt),
    .value0(cmp0),
    .value1(cmp1),
    .pending0(pend0),
    .pending1(pend1)
  );

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  run_clear_a: assert property (!run_q |=> counter_value == '0)
    else $error("counter not zero while stopped");
  trig_wait_a: assert property (run_q && !started_q |=> counter_value == '0)
    else $error("counter moved before trigger");
  trig_start_a: assert property (run_q && start_ext && !started_q && trig_evt
                                 |=> started_q)
    else $error("trigger edge did not start counting");
  soft_start_a: assert property (run_q && !start_ext |=> started_q)
    else $error("software start not taken");
  soft_cap_a: assert property (soft_cap |=> cap0_q == $past(counter_value))
    else $error("software capture missed");
  mode_read_a: assert property (ar_take && araddr == chan_pkg::OFF_MODE
                                |=> rdata[chan_pkg::B_SCAP])
    else $error("capture strobe bit read as zero");
  cap_off_a: assert property (cpm[0] == cpm[1] && !soft_cap
                              |=> $stable(cap0_q) && $stable(cap1_q))
    else $error("capture while disabled");
  cap_fall_a: assert property (cpm == chan_pkg::CPM_BOTH && pin_fall
                               |=> cap1_q == $past(counter_value))
    else $error("falling capture missed");
  match_clear_a: assert property (count_en && clear_en && match1
                                  |=> counter_value == '0)
    else $error("match clear missed");
  no_clear_a: assert property (count_en && !clear_en && !ovf
                               |=> counter_value == $past(counter_value) + 1'b1)
    else $error("counter did not advance");
  idle_stop_a: assert property (run_q && idle_req && !idle_run
                                |=> counter_value == $past(counter_value))
    else $error("counter moved in idle");
  pin_tick_a: assert property (run_q && clk_sel == chan_pkg::CLK_PIN && !pin_rise
                               |=> $stable(counter_value))
    else $error("pin count source wrong");
  buf_hold_a: assert property (wr_cmp0 && buffered && !load_evt |=> $stable(cmp0))
    else $error("buffered compare changed on write");
  forced_buf_a: assert property (op_select_q && !dbe && wr_cmp0 && !load_evt
                                 |=> $stable(cmp0))
    else $error("forced buffering not applied");
  pair_hold_a: assert property (buffered && pairing && load_evt && pend0 && !pend1
                                |=> $stable(cmp0))
    else $error("paired load done too early");

  match_clear_c: cover property (clear_hit);
  trig_start_c: cover property (run_q && start_ext && !started_q ##1 started_q);
  pair_load_c: cover property (pairing && pend0 && pend1 && load_evt);
  cap_both_c: cover property (cap_rise ##[1:50] cap_fall);
endmodule

// ### bench/pin_model.sv
// Purpose: far-side model of the external timer input pin
// Assumes: levels are held long enough for the two-stage synchroniser
// Notes: the pin changes right after a rising aclk edge
`timescale 1ns/1ns
module pin_model (
  // clock
  input wire logic aclk,
  // pin
  output logic timer_input_pin
);
  initial timer_input_pin = 1'b0;
  // one level change, launched after an edge
  task automatic level(input logic l);
    @(posedge aclk);
    timer_input_pin <= l;
  endtask
  // n high pulses of w+1 cycles high and w+1 low, prompt or slow
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      level(1'b1);
      repeat (w) @(posedge aclk);
      level(1'b0);
      repeat (w) @(posedge aclk);
    end
  endtask
endmodule

// ### bench/test_timer_channel_control_and_mode.sv
// Purpose: self-checking bench for one timer channel, control and mode
// Assumes: control and mode are rewritten only with the counter stopped
// Notes: prescaler off with run set freezes the counter at a known value
`timescale 1ns/1ns
module test_timer_channel_control_and_mode;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic idle_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, timer_input_pin;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v, c0, c1, a0, b0, v;
  logic [15:0] counter_value, v0, mx;
  logic [1:0] c;
  logic bf;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int i;

  always #10 aclk = ~aclk;

  timer_channel_control_and_mode u_timer_channel_control_and_mode (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .idle_req(idle_req), .timer_input_pin(timer_input_pin),
    .counter_value(counter_value));

  pin_model u_pin_model (.aclk(aclk), .timer_input_pin(timer_input_pin));

  task automatic results;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // axi4-lite write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read into rd_v and rsp
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // ticks of a prescaler tap within a window of cycles
  function automatic logic [31:0] tap_ticks(input logic [1:0] s, input int win);
    logic [4:0] m;
    m = (s == 2'b01) ? chan_pkg::TAP_T1 : (s == 2'b10) ? chan_pkg::TAP_T4 : chan_pkg::TAP_T16;
    return win / (int'(m) + 1);
  endfunction

  // capture register contents after one rising and one falling pin edge
  function automatic logic [31:0] cap_exp(input logic [1:0] s, input logic one,
                                          input logic [15:0] cnt, input logic [31:0] old);
    logic hit;
    hit = one ? (s == 2'b10) : (s == 2'b01 || s == 2'b10);
    return hit ? {16'h0, cnt} : old;
  endfunction

  initial begin
    rd_v = $urandom(32'h6e94);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(chan_pkg::OFF_CTRL);
    chk(rd_v, 32'h0, "control reset");
    rd(chan_pkg::OFF_MODE);
    chk(rd_v, {24'h0, chan_pkg::MODE_RD_SET}, "mode reset");
    rd(8'h40);
    chk({30'h0, rsp}, {30'h0, chan_pkg::RESP_SLVERR}, "unmapped read");
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      wr(chan_pkg::OFF_CTRL, v);
      rd(chan_pkg::OFF_CTRL);
      chk(rd_v, {24'h0, v[7:0] & chan_pkg::CTRL_MASK}, "control rw");
      wr(chan_pkg::OFF_MODE, v | 32'h20);
      rd(chan_pkg::OFF_MODE);
      chk(rd_v, {24'h0, (v[7:0] & chan_pkg::MODE_MASK) | 8'h20}, "mode rw");
    end
    wr(chan_pkg::OFF_CTRL, 32'h0);
    // prescaler taps
    for (i = 1; i < 4; i++) begin
      c = i[1:0];
      wr(chan_pkg::OFF_MODE, 32'h20 | i);
      wr(chan_pkg::OFF_RUN, 32'h5);
      repeat (40) @(posedge aclk);
      v0 = counter_value;
      repeat (64) @(posedge aclk);
      chk({16'h0, counter_value - v0}, tap_ticks(c, 64), "tap rate");
      wr(chan_pkg::OFF_RUN, 32'h0);
      repeat (2) @(posedge aclk);
      chk({16'h0, counter_value}, 32'h0, "stop clears");
    end
    // pin as count source
    wr(chan_pkg::OFF_MODE, 32'h20);
    wr(chan_pkg::OFF_RUN, 32'h1);
    v = 1 + $urandom % 5;
    u_pin_model.pulses(v, 2 + $urandom % 4);
    repeat (8) @(posedge aclk);
    chk({16'h0, counter_value}, v, "pin count");
    wr(chan_pkg::OFF_RUN, 32'h0);
    // idle state, clock stopped then kept running
    wr(chan_pkg::OFF_MODE, 32'h21);
    for (i = 0; i < 2; i++) begin
      wr(chan_pkg::OFF_CTRL, i << 3);
      wr(chan_pkg::OFF_RUN, 32'h5);
      @(posedge aclk);
      idle_req <= 1'b1;
      repeat (4) @(posedge aclk);
      v0 = counter_value;
      repeat (32) @(posedge aclk);
      chk({16'h0, counter_value - v0}, (i == 1) ? tap_ticks(2'b01, 32) : 32'h0, "idle");
      idle_req <= 1'b0;
      wr(chan_pkg::OFF_RUN, 32'h0);
    end
    wr(chan_pkg::OFF_CTRL, 32'h0);
    // clear on compare 1 match
    wr(chan_pkg::OFF_MODE, 32'h25);
    wr(chan_pkg::OFF_CMP1, 32'h9);
    wr(chan_pkg::OFF_RUN, 32'h5);
    mx = 16'h0;
    repeat (200) begin
      @(posedge aclk);
      if (counter_value > mx) mx = counter_value;
    end
    chk({16'h0, mx}, 32'h9, "match clear");
    wr(chan_pkg::OFF_RUN, 32'h0);
    wr(chan_pkg::OFF_MODE, 32'h21);
    wr(chan_pkg::OFF_RUN, 32'h5);
    repeat (64) @(posedge aclk);
    chk({31'h0, counter_value > 16'h9}, 32'h1, "no clear");
    // trigger start, wrong edge first, then the selected one
    for (i = 0; i < 2; i++) begin
      wr(chan_pkg::OFF_RUN, 32'h0);
      u_pin_model.level(i == 0);
      wr(chan_pkg::OFF_CTRL, 32'h1 | (i << 1));
      wr(chan_pkg::OFF_RUN, 32'h5);
      u_pin_model.level(i == 1);
      repeat (40) @(posedge aclk);
      chk({16'h0, counter_value}, 32'h0, "held at zero");
      u_pin_model.level(i == 0);
      repeat (20) @(posedge aclk);
      chk({31'h0, counter_value != 16'h0}, 32'h1, "trigger start");
    end
    wr(chan_pkg::OFF_RUN, 32'h0);
    wr(chan_pkg::OFF_CTRL, 32'h0);
    // capture timing codes on a frozen counter
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(chan_pkg::OFF_RUN, 32'h0);
      wr(chan_pkg::OFF_MODE, 32'h21 | (i << 3));
      wr(chan_pkg::OFF_RUN, 32'h5);
      repeat (20 + $urandom % 30) @(posedge aclk);
      wr(chan_pkg::OFF_RUN, 32'h1);
      repeat (4) @(posedge aclk);
      v0 = counter_value;
      rd(chan_pkg::OFF_CAP0);
      c0 = rd_v;
      rd(chan_pkg::OFF_CAP1);
      c1 = rd_v;
      u_pin_model.pulses(1, 8);
      rd(chan_pkg::OFF_CAP0);
      chk(rd_v, cap_exp(c, 1'b0, v0, c0), "capture 0");
      rd(chan_pkg::OFF_CAP1);
      chk(rd_v, cap_exp(c, 1'b1, v0, c1), "capture 1");
    end
    // software capture with the counter stopped at zero
    wr(chan_pkg::OFF_RUN, 32'h0);
    rd(chan_pkg::OFF_CAP0);
    c0 = rd_v;
    wr(chan_pkg::OFF_MODE, 32'h21);
    rd(chan_pkg::OFF_CAP0);
    chk(rd_v, c0, "soft capture one");
    wr(chan_pkg::OFF_MODE, 32'h01);
    rd(chan_pkg::OFF_CAP0);
    chk(rd_v, 32'h0, "soft capture zero");
    rd(chan_pkg::OFF_MODE);
    chk(rd_v, 32'h21, "strobe reads one");
    // compare buffering: operating select, buffer enable, pairing
    for (i = 0; i < 8; i++) begin
      bf = i[2] | i[1];
      wr(chan_pkg::OFF_RUN, 32'h0);
      wr(chan_pkg::OFF_ENABLE, {31'h0, i[2]});
      wr(chan_pkg::OFF_CTRL, {24'h0, i[1], 7'h0});
      wr(chan_pkg::OFF_MODE, 32'h20 | (i[0] << 6));
      a0 = {16'h0, 16'($urandom)};
      b0 = {16'h0, 16'($urandom)};
      v = {16'h0, 16'($urandom)};
      wr(chan_pkg::OFF_CMP0, a0);
      wr(chan_pkg::OFF_CMP1, a0);
      wr(chan_pkg::OFF_RUN, 32'h1);
      wr(chan_pkg::OFF_CMP0, b0);
      rd(chan_pkg::OFF_CMP0);
      chk(rd_v, bf ? a0 : b0, "buffered write");
      wr(chan_pkg::OFF_RUN, 32'h0);
      repeat (2) @(posedge aclk);
      rd(chan_pkg::OFF_CMP0);
      chk(rd_v, (bf && i[0]) ? a0 : b0, "paired hold");
      wr(chan_pkg::OFF_CMP1, v);
      repeat (2) @(posedge aclk);
      rd(chan_pkg::OFF_CMP0);
      chk(rd_v, b0, "pair load 0");
      rd(chan_pkg::OFF_CMP1);
      chk(rd_v, v, "pair load 1");
    end
    results();
  end
endmodule
